/* File: common/rtc_pkg.sv */
// Purpose: Constants and carrier types for the backup-domain real-time clock
// Assumes: 32-bit register words at byte offsets, 16-bit halves for values
// Notes:   Shared by the core and by the verification side
package rtc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PSC_W  = 20;
  localparam int unsigned CNT_W  = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned PSC_HI_W = PSC_W - HALF_W;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PSC_HI     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PSC_LO     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DIV_HI     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DIV_LO     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_ALM_HI     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ALM_LO     = 8'h24;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned IE_SECOND   = 0;
  localparam int unsigned IE_ALARM    = 1;
  localparam int unsigned IE_OVERFLOW = 2;
  localparam int unsigned IE_W        = 3;

  localparam int unsigned CTL_SECOND    = 0;
  localparam int unsigned CTL_ALARM     = 1;
  localparam int unsigned CTL_OVERFLOW  = 2;
  localparam int unsigned CTL_RESYNC    = 3;
  localparam int unsigned CTL_CONFIG    = 4;
  localparam int unsigned CTL_WR_FINISH = 5;

  // Staged-write pending bits, one per 16-bit half
  localparam int unsigned PEND_PSC_HI = 0;
  localparam int unsigned PEND_PSC_LO = 1;
  localparam int unsigned PEND_CNT_HI = 2;
  localparam int unsigned PEND_CNT_LO = 3;
  localparam int unsigned PEND_ALM_HI = 4;
  localparam int unsigned PEND_ALM_LO = 5;
  localparam int unsigned PEND_W      = 6;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0020;
  localparam logic [IE_W-1:0]   IE_RESET      = 3'h0;
  localparam logic [PSC_W-1:0]  PSC_RESET     = 20'h0_0000;
  localparam logic [CNT_W-1:0]  CNT_RESET     = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  ALM_RESET     = 32'hffff_ffff;
  localparam logic [1:0]        COMMIT_LAST   = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // Peripheral bus request carrier
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef enum logic {
    COMMIT_IDLE,
    COMMIT_BUSY
  } commit_state_t;

endpackage : rtc_pkg

/* File: core/backup_domain_rtc_core.sv */
// Purpose: Real-time clock core with peripheral bus register interface
// Assumes: rtc_clk_in is at most a quarter of clk; sampled, not a clock
// Notes:   Core state is cleared only by bkp_rst_n; rst_n clears the bus side
// Behaviour
// RL1: Twenty-bit prescaler divides source into ticks
// RL2: Thirty-two-bit counter advances once per tick
// RL3: Second enable requests interrupt every tick
// RL4: Alarm enable requests interrupt on match
// RL5: System reset clears bus side, enables
// RL6: Core clock at most quarter bus clock
// RL7: Counter, divider and flags refresh per edge
// RL8: Resync flag set again after update
// RL9: Value writes accepted only in configuration
// RL10: Commit on exit, three core edges
// RL11: Software follows finish, config, write order
// RL12: Second flag on last cycle before increment
// RL13: Alarm flag before matching counter increments
// RL14: Overflow flag before counter wraps zero
// RL15: Software aligns updates with the tick
// RL16: Enable bits overflow2 alarm1 second0
// RL17: Control fields and reset value 0x0020
// RL18: Global request from flag and enable
// RL19: Alarm event drives external line seventeen
// RL20: Divider reload sets second, increments counter
// RL21: Configuration and time survive device reset
// RL22: Software enables backup access first
// RL23: Tick rate is source over prescale+1
// RL24: Divider reloads on prescale or counter update
// RL25: Alarm halves reset to all ones
// RL26: Counter wraps to zero and continues
`timescale 1ns/1ns
module backup_domain_rtc_core (
  input  wire logic             clk,         // bus clock, 125 MHz
  input  wire logic             rst_n,       // system reset, sync, low
  input  wire logic             bkp_rst_n,   // backup-domain reset, low
  input  wire logic             ce,          // clock enable, freezes all
  input  wire logic             rtc_clk_in,  // RTC source clock level
  input  wire rtc_pkg::apb_req_t bus_req,    // bus request signals
  output logic [31:0]           prdata,      // read data, registered
  output logic                  pready,      // always ready
  output logic                  pslverr,     // unmapped access error
  output logic                  irq,         // global interrupt request
  output logic                  alarm_event  // to event controller line 17
);

  ////////////////////////////////////////////////////////////////////////////
  // Source clock sampling, three stages then a stable level
  // Idle pin is low, so the cleared level gives no false edge
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  wire  agree    = (sync2_ff == sync3_ff);
  wire  rtc_edge = agree & sync3_ff & ~level_ff;

  always_ff @(posedge clk) begin
    if (!bkp_rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else if (ce) begin
      sync1_ff <= rtc_clk_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (agree) begin
        level_ff <= sync3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [rtc_pkg::ADDR_W-1:0] addr  = bus_req.paddr;
  wire [rtc_pkg::DATA_W-1:0] wdata = bus_req.pwdata;
  wire access   = bus_req.psel & bus_req.penable;
  wire setup    = bus_req.psel & ~bus_req.penable;
  wire wr       = access & bus_req.pwrite;
  wire rd_setup = setup & ~bus_req.pwrite;

  wire hit_ie     = (addr == rtc_pkg::OFF_IRQ_ENABLE);
  wire hit_ctl    = (addr == rtc_pkg::OFF_CONTROL);
  wire hit_psc_hi = (addr == rtc_pkg::OFF_PSC_HI);
  wire hit_psc_lo = (addr == rtc_pkg::OFF_PSC_LO);
  wire hit_div_hi = (addr == rtc_pkg::OFF_DIV_HI);
  wire hit_div_lo = (addr == rtc_pkg::OFF_DIV_LO);
  wire hit_cnt_hi = (addr == rtc_pkg::OFF_CNT_HI);
  wire hit_cnt_lo = (addr == rtc_pkg::OFF_CNT_LO);
  wire hit_alm_hi = (addr == rtc_pkg::OFF_ALM_HI);
  wire hit_alm_lo = (addr == rtc_pkg::OFF_ALM_LO);
  wire mapped = hit_ie | hit_ctl | hit_psc_hi | hit_psc_lo | hit_div_hi
              | hit_div_lo | hit_cnt_hi | hit_cnt_lo | hit_alm_hi
              | hit_alm_lo;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Bus-side registers
  logic [rtc_pkg::IE_W-1:0]   ie_ff;
  logic                       cnf_ff;
  logic                       sec_ff;
  logic                       alm_flag_ff;
  logic                       ovf_ff;
  logic                       rsf_ff;
  logic [rtc_pkg::PEND_W-1:0] pend_ff;
  logic [rtc_pkg::PSC_W-1:0]  stg_psc_ff;
  logic [rtc_pkg::CNT_W-1:0]  stg_cnt_ff;
  logic [rtc_pkg::CNT_W-1:0]  stg_alm_ff;
  logic [1:0]                 commit_cnt_ff;
  rtc_pkg::commit_state_t     state_ff;
  rtc_pkg::commit_state_t     nxt_state;
  logic [31:0]                prdata_ff;

  // Core registers, backup domain
  logic [rtc_pkg::PSC_W-1:0]  psc_ff;
  logic [rtc_pkg::PSC_W-1:0]  div_ff;
  logic [rtc_pkg::CNT_W-1:0]  cnt_ff;
  logic [rtc_pkg::CNT_W-1:0]  alm_ff;

  wire busy      = (state_ff == rtc_pkg::COMMIT_BUSY);
  wire wr_ctl    = wr & hit_ctl;
  // Staging only while configuring and no commit in flight
  wire stage_ok  = wr & cnf_ff & ~busy; // RL9
  wire cnf_exit  = wr_ctl & cnf_ff & ~wdata[rtc_pkg::CTL_CONFIG];
  wire apply     = rtc_edge & busy
                 & (commit_cnt_ff == rtc_pkg::COMMIT_LAST); // RL10

  wire [rtc_pkg::PEND_W-1:0] pend_set = {
    stage_ok & hit_alm_lo, stage_ok & hit_alm_hi,
    stage_ok & hit_cnt_lo, stage_ok & hit_cnt_hi,
    stage_ok & hit_psc_lo, stage_ok & hit_psc_hi};

  ////////////////////////////////////////////////////////////////////////////
  // Free-running divider and counter step
  wire div_zero = (div_ff == '0);
  // Divider reload is the increment moment
  wire [rtc_pkg::PSC_W-1:0] base_div =
    div_zero ? psc_ff : div_ff - 20'h0_0001; // RL1 RL23 RL20
  // Natural wrap to zero after all ones
  wire [rtc_pkg::CNT_W-1:0] base_cnt =
    div_zero ? cnt_ff + 32'h0000_0001 : cnt_ff; // RL2 RL26

  ////////////////////////////////////////////////////////////////////////////
  // Merge of staged halves with live values
  wire [rtc_pkg::PSC_HI_W-1:0] m_psc_hi = pend_ff[rtc_pkg::PEND_PSC_HI]
    ? stg_psc_ff[rtc_pkg::PSC_W-1:rtc_pkg::HALF_W]
    : psc_ff[rtc_pkg::PSC_W-1:rtc_pkg::HALF_W];
  wire [rtc_pkg::HALF_W-1:0] m_psc_lo = pend_ff[rtc_pkg::PEND_PSC_LO]
    ? stg_psc_ff[rtc_pkg::HALF_W-1:0] : psc_ff[rtc_pkg::HALF_W-1:0];
  wire [rtc_pkg::HALF_W-1:0] m_cnt_hi = pend_ff[rtc_pkg::PEND_CNT_HI]
    ? stg_cnt_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W]
    : base_cnt[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W];
  wire [rtc_pkg::HALF_W-1:0] m_cnt_lo = pend_ff[rtc_pkg::PEND_CNT_LO]
    ? stg_cnt_ff[rtc_pkg::HALF_W-1:0] : base_cnt[rtc_pkg::HALF_W-1:0];
  wire [rtc_pkg::HALF_W-1:0] m_alm_hi = pend_ff[rtc_pkg::PEND_ALM_HI]
    ? stg_alm_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W]
    : alm_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W];
  wire [rtc_pkg::HALF_W-1:0] m_alm_lo = pend_ff[rtc_pkg::PEND_ALM_LO]
    ? stg_alm_ff[rtc_pkg::HALF_W-1:0] : alm_ff[rtc_pkg::HALF_W-1:0];

  wire psc_written = pend_ff[rtc_pkg::PEND_PSC_HI]
                   | pend_ff[rtc_pkg::PEND_PSC_LO];
  wire cnt_written = pend_ff[rtc_pkg::PEND_CNT_HI]
                   | pend_ff[rtc_pkg::PEND_CNT_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Core next state
  wire [rtc_pkg::PSC_W-1:0] m_psc = {m_psc_hi, m_psc_lo};
  wire reload_now = apply & (psc_written | cnt_written);
  wire [rtc_pkg::PSC_W-1:0] nxt_psc = apply ? m_psc : psc_ff;
  wire [rtc_pkg::PSC_W-1:0] nxt_div =
    reload_now ? m_psc : base_div; // RL24
  wire [rtc_pkg::CNT_W-1:0] nxt_cnt =
    (apply & cnt_written) ? {m_cnt_hi, m_cnt_lo} : base_cnt;
  wire [rtc_pkg::CNT_W-1:0] nxt_alm =
    apply ? {m_alm_hi, m_alm_lo} : alm_ff;

  // Divider about to hit zero: next edge increments the counter
  wire sec_evt = rtc_edge & (nxt_div == '0); // RL12 RL20
  wire alm_evt = sec_evt & (nxt_cnt == nxt_alm); // RL13
  wire ovf_evt = sec_evt & (&nxt_cnt); // RL14

  // Core keeps counting through system reset
  always_ff @(posedge clk) begin
    if (!bkp_rst_n) begin // RL5 RL21
      psc_ff <= rtc_pkg::PSC_RESET;
      div_ff <= rtc_pkg::PSC_RESET;
      cnt_ff <= rtc_pkg::CNT_RESET;
      alm_ff <= rtc_pkg::ALM_RESET; // RL25
    end else if (ce && rtc_edge) begin
      psc_ff <= nxt_psc;
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      alm_ff <= nxt_alm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit sequencer
  // System reset abandons a commit in flight with its staged data
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rtc_pkg::COMMIT_IDLE: begin
        if (cnf_exit && (pend_ff != '0)) begin
          nxt_state = rtc_pkg::COMMIT_BUSY;
        end
      end
      rtc_pkg::COMMIT_BUSY: begin
        if (apply) begin
          nxt_state = rtc_pkg::COMMIT_IDLE;
        end
      end
      default: nxt_state = rtc_pkg::COMMIT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff      <= rtc_pkg::COMMIT_IDLE;
      commit_cnt_ff <= 2'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (!busy) begin
        commit_cnt_ff <= 2'h0;
      end else if (rtc_edge) begin
        commit_cnt_ff <= commit_cnt_ff + 2'h1; // RL10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff    <= '0;
      stg_psc_ff <= rtc_pkg::PSC_RESET;
      stg_cnt_ff <= rtc_pkg::CNT_RESET;
      stg_alm_ff <= rtc_pkg::ALM_RESET;
    end else if (ce) begin
      pend_ff <= apply ? '0 : (pend_ff | pend_set);
      if (pend_set[rtc_pkg::PEND_PSC_HI]) begin
        stg_psc_ff[rtc_pkg::PSC_W-1:rtc_pkg::HALF_W] <=
          wdata[rtc_pkg::PSC_HI_W-1:0];
      end
      if (pend_set[rtc_pkg::PEND_PSC_LO]) begin
        stg_psc_ff[rtc_pkg::HALF_W-1:0] <= wdata[rtc_pkg::HALF_W-1:0];
      end
      if (pend_set[rtc_pkg::PEND_CNT_HI]) begin
        stg_cnt_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W] <=
          wdata[rtc_pkg::HALF_W-1:0];
      end
      if (pend_set[rtc_pkg::PEND_CNT_LO]) begin
        stg_cnt_ff[rtc_pkg::HALF_W-1:0] <= wdata[rtc_pkg::HALF_W-1:0];
      end
      if (pend_set[rtc_pkg::PEND_ALM_HI]) begin
        stg_alm_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W] <=
          wdata[rtc_pkg::HALF_W-1:0];
      end
      if (pend_set[rtc_pkg::PEND_ALM_LO]) begin
        stg_alm_ff[rtc_pkg::HALF_W-1:0] <= wdata[rtc_pkg::HALF_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, flags and enables; a hardware set beats a software clear
  wire clr_sec = wr_ctl & ~wdata[rtc_pkg::CTL_SECOND];
  wire clr_alm = wr_ctl & ~wdata[rtc_pkg::CTL_ALARM];
  wire clr_ovf = wr_ctl & ~wdata[rtc_pkg::CTL_OVERFLOW];
  wire clr_rsf = wr_ctl & ~wdata[rtc_pkg::CTL_RESYNC];

  wire nxt_sec = sec_evt | (sec_ff & ~clr_sec);
  wire nxt_alm_flag = alm_evt | (alm_flag_ff & ~clr_alm);
  wire nxt_ovf = ovf_evt | (ovf_ff & ~clr_ovf);
  // Any core edge is a completed refresh of the readable copies
  wire nxt_rsf = rtc_edge | (rsf_ff & ~clr_rsf); // RL7 RL8
  // Flags sit on the bus side, so system reset clears them

  always_ff @(posedge clk) begin
    if (!rst_n) begin // RL5
      ie_ff       <= rtc_pkg::IE_RESET;
      cnf_ff      <= rtc_pkg::CONTROL_RESET[rtc_pkg::CTL_CONFIG];
      sec_ff      <= rtc_pkg::CONTROL_RESET[rtc_pkg::CTL_SECOND];
      alm_flag_ff <= rtc_pkg::CONTROL_RESET[rtc_pkg::CTL_ALARM];
      ovf_ff      <= rtc_pkg::CONTROL_RESET[rtc_pkg::CTL_OVERFLOW];
      rsf_ff      <= rtc_pkg::CONTROL_RESET[rtc_pkg::CTL_RESYNC];
    end else if (ce) begin
      if (wr && hit_ie) begin
        ie_ff <= wdata[rtc_pkg::IE_W-1:0]; // RL16
      end
      if (wr_ctl) begin
        cnf_ff <= wdata[rtc_pkg::CTL_CONFIG]; // RL17
      end
      sec_ff      <= nxt_sec; // RL17
      alm_flag_ff <= nxt_alm_flag;
      ovf_ff      <= nxt_ovf;
      rsf_ff      <= nxt_rsf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and event outputs
  assign irq = (sec_ff & ie_ff[rtc_pkg::IE_SECOND])          // RL3 RL18
             | (alm_flag_ff & ie_ff[rtc_pkg::IE_ALARM])      // RL4
             | (ovf_ff & ie_ff[rtc_pkg::IE_OVERFLOW]);
  assign alarm_event = alm_flag_ff; // RL19

  ////////////////////////////////////////////////////////////////////////////
  // Read path; prescaler and alarm are write-only from the core
  wire [31:0] ie_rd  = {{(32-rtc_pkg::IE_W){1'b0}}, ie_ff};
  // Write finished reads low only while a commit waits for edges
  wire [31:0] ctl_rd = {26'h000_0000, ~busy, cnf_ff, rsf_ff, ovf_ff,
                        alm_flag_ff, sec_ff}; // RL17
  wire [31:0] div_hi_rd = {28'h000_0000,
                           div_ff[rtc_pkg::PSC_W-1:rtc_pkg::HALF_W]};
  wire [31:0] div_lo_rd = {16'h0000, div_ff[rtc_pkg::HALF_W-1:0]};
  wire [31:0] cnt_hi_rd = {16'h0000,
                           cnt_ff[rtc_pkg::CNT_W-1:rtc_pkg::HALF_W]};
  wire [31:0] cnt_lo_rd = {16'h0000, cnt_ff[rtc_pkg::HALF_W-1:0]};
  wire [31:0] rd_mux = hit_ie     ? ie_rd
                     : hit_ctl    ? ctl_rd
                     : hit_div_hi ? div_hi_rd // RL7
                     : hit_div_lo ? div_lo_rd
                     : hit_cnt_hi ? cnt_hi_rd
                     : hit_cnt_lo ? cnt_lo_rd
                     : 32'h0000_0000;

  // Captured in setup so the access phase sees a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (ce && rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;

endmodule : backup_domain_rtc_core

/* File: sim/bus_master_model.sv */
// Purpose: Peripheral bus master standing in for the processor
// Assumes: Zero wait states; requests change on falling edges
// Notes:   Released lines carry the inverse of the last value
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic        clk,      // bus clock
  output rtc_pkg::apb_req_t bus_req, // request to the core
  input  wire logic [31:0] prdata,   // read data
  input  wire logic        pslverr   // access error
);
  logic err_seen;

  initial bus_req = '0;
  initial err_seen = 1'b0;

  // Holds the request until the edge that samples the answer
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    bus_req = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                pwdata: d};
    @(negedge clk);
    bus_req.penable = 1'b1;
    @(posedge clk);
    q = prdata;
    err_seen = pslverr;
    @(negedge clk);
    // Stale address or data must never look valid once released
    bus_req = '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a,
                pwdata: ~d};
  endtask : xfer
endmodule : bus_master_model

/* File: sim/backup_domain_rtc_core_asserts.sv */
// Purpose: Port-level checks for the real-time clock core
// Assumes: ce held high; enables shadowed from bus writes
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ns
module backup_domain_rtc_core_asserts (
  input wire logic              clk,         // bus clock
  input wire logic              rst_n,       // system reset
  input wire logic              bkp_rst_n,   // backup reset
  input wire logic              ce,          // clock enable
  input wire logic              rtc_clk_in,  // source clock level
  input wire rtc_pkg::apb_req_t bus_req,     // bus request
  input wire logic [31:0]       prdata,      // read data
  input wire logic              pready,      // ready
  input wire logic              pslverr,     // error
  input wire logic              irq,         // global request
  input wire logic              alarm_event  // event line
);
  logic [2:0] ie_sh_ff;
  logic [3:0] since_edge_ff;
  logic       rtc_prev_ff;
  wire acc = bus_req.psel & bus_req.penable;
  wire wr_acc = acc & bus_req.pwrite & ce;
  wire unmapped = (bus_req.paddr > rtc_pkg::OFF_ALM_LO) |
                  (|bus_req.paddr[1:0]);
  wire ie_wr = wr_acc & (bus_req.paddr == rtc_pkg::OFF_IRQ_ENABLE);
  wire alm_clr = wr_acc & (bus_req.paddr == rtc_pkg::OFF_CONTROL) &
                 ~bus_req.pwdata[1];
  wire rd_setup = bus_req.psel & ~bus_req.penable & ~bus_req.pwrite;

  always_ff @(posedge clk) begin
    if (!rst_n) ie_sh_ff <= 3'h0;
    else if (ie_wr) ie_sh_ff <= bus_req.pwdata[2:0];
  end

  // Cycles since a raw source rise; bounds the synchroniser delay
  always_ff @(posedge clk) begin
    if (!bkp_rst_n) begin
      rtc_prev_ff   <= 1'b0;
      since_edge_ff <= 4'hf;
    end else begin
      rtc_prev_ff <= rtc_clk_in;
      if (rtc_clk_in & ~rtc_prev_ff) since_edge_ff <= 4'h0;
      else if (since_edge_ff != 4'hf) since_edge_ff <= since_edge_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_irq_rst_low:
    assert property (disable iff (1'b0) !rst_n |=> !irq)
    else $error("irq high after system reset");
  chk_alarm_rst_low:
    assert property (disable iff (1'b0) !rst_n |=> !alarm_event)
    else $error("alarm event high after system reset");
  chk_unmapped_err:
    assert property (acc && unmapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_mapped_ok:
    assert property (acc && !unmapped |-> !pslverr)
    else $error("error on mapped access");
  chk_alarm_irq_path:
    assert property (alarm_event && ie_sh_ff[1] |-> irq)
    else $error("enabled alarm flag without irq");
  chk_irq_no_enable:
    assert property (ie_sh_ff == 3'h0 |-> !irq)
    else $error("irq with all enables clear");
  chk_alarm_flag_holds:
    assert property (alarm_event && !alm_clr |=> alarm_event)
    else $error("alarm flag dropped without clear");
  chk_flag_after_edge:
    assert property ($rose(alarm_event) |-> since_edge_ff inside {[2:7]})
    else $error("alarm flag not tied to a source edge");
  chk_prdata_hold:
    assert property (!rd_setup |=> $stable(prdata))
    else $error("read data changed outside read setup");

  cov_alarm: cover property ($rose(alarm_event));
  cov_ovf_irq: cover property (irq && ie_sh_ff[2]);
  cov_err: cover property (acc && pslverr);
endmodule : backup_domain_rtc_core_asserts

bind backup_domain_rtc_core backup_domain_rtc_core_asserts i_asserts (
  .clk(clk), .rst_n(rst_n), .bkp_rst_n(bkp_rst_n), .ce(ce),
  .rtc_clk_in(rtc_clk_in), .bus_req(bus_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq),
  .alarm_event(alarm_event));

/* File: sim/backup_domain_rtc_core_test.sv */
// Purpose: Self-checking bench for the real-time clock core
// Assumes: Source clock at clk/8; LFSR stimulus from a fixed seed
// Notes:   All waits bounded; a hang runs into the cycle ceiling
`timescale 1ns/1ns
module backup_domain_rtc_core_test;
  localparam int LIMIT = 40000;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              bkp_rst_n = 1'b0;
  logic              ce = 1'b1;
  logic              rtc_clk_in = 1'b0;
  logic              rtc_run = 1'b0;
  logic [2:0]        ph = 3'h0;
  logic [31:0]       rd, base, seed = 32'h59cfc277;
  logic [19:0]       prescale_value;
  logic              pready, pslverr, irq, alarm_event;
  logic [31:0]       prdata;
  rtc_pkg::apb_req_t bus_req;
  int                num_errors = 0;
  int                n_compared = 0;
  int                cycles = 0;
  int                t0;

  always #4 clk = ~clk;
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    rtc_clk_in <= rtc_run & ph[2];
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  backup_domain_rtc_core i_backup_domain_rtc_core (
    .clk(clk), .rst_n(rst_n), .bkp_rst_n(bkp_rst_n), .ce(ce),
    .rtc_clk_in(rtc_clk_in), .bus_req(bus_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .alarm_event(alarm_event));
  bus_master_model i_bus_master_model (
    .clk(clk), .bus_req(bus_req), .prdata(prdata), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_bus_master_model.xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_at(input logic [7:0] a);
    i_bus_master_model.xfer(1'b0, a, 32'h0, rd);
  endtask : rd_at

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_at(a);
    cmp_val(rd, exp);
  endtask : rd_chk

  task automatic poll(input int b);
    rd_at(rtc_pkg::OFF_CONTROL);
    for (int k = 0; k < 200 && rd[b] !== 1'b1; k++)
      rd_at(rtc_pkg::OFF_CONTROL);
    cmp_bit(rd[b], 1'b1);
  endtask : poll

  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 800 && s !== 1'b1; k++) @(negedge clk);
    cmp_bit(s, 1'b1);
  endtask : wait_hi

  task automatic configure(input logic [19:0] p, input logic [31:0] c,
                           input logic [31:0] a);
    poll(rtc_pkg::CTL_WR_FINISH);
    wr(rtc_pkg::OFF_CONTROL, 32'h10);
    wr(rtc_pkg::OFF_PSC_HI, {28'h0, p[19:16]});
    wr(rtc_pkg::OFF_PSC_LO, {16'h0, p[15:0]});
    wr(rtc_pkg::OFF_CNT_HI, {16'h0, c[31:16]});
    wr(rtc_pkg::OFF_CNT_LO, {16'h0, c[15:0]});
    wr(rtc_pkg::OFF_ALM_HI, {16'h0, a[31:16]});
    wr(rtc_pkg::OFF_ALM_LO, {16'h0, a[15:0]});
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    rd_at(rtc_pkg::OFF_CONTROL);
    cmp_bit(rd[rtc_pkg::CTL_WR_FINISH], 1'b0);
    poll(rtc_pkg::CTL_WR_FINISH);
    cmp_bit(rd[rtc_pkg::CTL_WR_FINISH], 1'b1);
    rd_chk(rtc_pkg::OFF_CNT_HI, {16'h0, c[31:16]});
    rd_chk(rtc_pkg::OFF_CNT_LO, {16'h0, c[15:0]});
  endtask : configure

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    bkp_rst_n <= 1'b1;
    rd_chk(rtc_pkg::OFF_IRQ_ENABLE, 32'h0);
    rd_chk(rtc_pkg::OFF_CONTROL, rtc_pkg::CONTROL_RESET);
    cmp_bit(pready, 1'b1);
    rd_chk(8'h40, 32'h0);
    cmp_bit(i_bus_master_model.err_seen, 1'b1);
    wr(rtc_pkg::OFF_CNT_LO, 32'h1234);
    rd_chk(rtc_pkg::OFF_CNT_LO, 32'h0);
    rd_chk(rtc_pkg::OFF_ALM_LO, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = step(seed);
      wr(rtc_pkg::OFF_IRQ_ENABLE, seed);
      rd_chk(rtc_pkg::OFF_IRQ_ENABLE, {29'h0, seed[2:0]});
    end
    wr(rtc_pkg::OFF_IRQ_ENABLE, 32'h0);
    $display("reset and map test done");
    rtc_run <= 1'b1;
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    poll(rtc_pkg::CTL_RESYNC);
    cmp_bit(rd[rtc_pkg::CTL_RESYNC], 1'b1);
    seed = step(seed);
    prescale_value = {17'h0, seed[2:0]} + 20'h3;
    base = step(seed);
    configure(prescale_value, base, base + 32'h3);
    $display("configuration test done");
    wr(rtc_pkg::OFF_IRQ_ENABLE, 32'h1);
    wait_hi(irq);
    rd_chk(rtc_pkg::OFF_CNT_LO, {16'h0, base[15:0]});
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    cmp_bit(irq, 1'b0);
    // First flag predates the commit; time two later ticks
    wait_hi(irq);
    t0 = cycles;
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    wait_hi(irq);
    cmp_val(32'(cycles - t0), 32'(8 * (int'(prescale_value) + 1)));
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    wr(rtc_pkg::OFF_IRQ_ENABLE, 32'h2);
    wait_hi(alarm_event);
    cmp_bit(irq, 1'b1);
    rd_chk(rtc_pkg::OFF_CNT_LO, {16'h0, base[15:0] + 16'h3});
    $display("tick and alarm test done");
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    poll(rtc_pkg::CTL_SECOND);
    configure(prescale_value, 32'hffff_fffe, 32'h0);
    wr(rtc_pkg::OFF_IRQ_ENABLE, 32'h4);
    wait_hi(irq);
    rd_chk(rtc_pkg::OFF_CNT_HI, 32'hffff);
    rd_chk(rtc_pkg::OFF_CNT_LO, 32'hffff);
    wr(rtc_pkg::OFF_CONTROL, 32'h0);
    poll(rtc_pkg::CTL_SECOND);
    rd_chk(rtc_pkg::OFF_CNT_LO, 32'h0);
    rd_at(rtc_pkg::OFF_CNT_LO);
    base = rd;
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    cmp_bit(alarm_event, 1'b0);
    rd_chk(rtc_pkg::OFF_IRQ_ENABLE, 32'h0);
    poll(rtc_pkg::CTL_RESYNC);
    rd_at(rtc_pkg::OFF_CNT_LO);
    cmp_bit(rd >= base && rd <= base + 32'h1, 1'b1);
    $display("overflow and reset test done");
    close_out();
  end
endmodule : backup_domain_rtc_core_test
